// ==== design/virtual_partition_id_map_regs.sv ====
// Purpose: Upper virtual-to-physical partition map registers six and seven
// Assumes: One request per cycle from the execution pipeline, answered next cycle
// Notes: Also translates a virtual identifier for lookups in entries 24 to 31
`include "vpm_params.svh"

module virtual_partition_id_map_regs
#(
	parameter logic [2:0] HIGHEST_INDEX = 3'h7,
	parameter bit HYP_CONTROL = 1'b1
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire vpm_pkg::sysreg_req_s req,
	input wire vpm_pkg::level_e current_privilege_level,
	input wire vpm_pkg::access_ctx_s ctx_in,
	input wire logic [31:0] mapping_valid_bits_reg,
	input wire logic kernel_map_enable,
	input wire logic user_map_enable,
	input wire logic xlat_req,
	input wire logic xlat_is_kernel,
	input wire logic [4:0] xlat_virtual_id,
	output vpm_pkg::sysreg_rsp_s rsp,
	output logic [2:0] highest_map_reg_index,
	output logic xlat_hit,
	output logic [15:0] xlat_physical_id
);

	// Registers zero to five live elsewhere, so a smaller index has nothing to serve here
	generate
		if (HIGHEST_INDEX < 3'h6)
		begin : g_bad_index
			$error("Bank only serves register six and up");
		end
	endgenerate

	// --------------------------------------------
	// Storage and decode
	// --------------------------------------------
	logic [`VPM_ENTRY_W-1:0] entry_r [0:7];
	logic hit_six;
	logic hit_upper;
	logic hit_any;
	logic present_six;
	logic present_upper;
	vpm_pkg::access_ctx_s ctx;
	vpm_pkg::outcome_e outcome;

	function automatic logic enc_match(input vpm_pkg::sysreg_req_s r, input logic [2:0] op2);
		enc_match = r.valid && r.op0 == `VPM_OP0 && r.op1 == `VPM_OP1 && r.crn == `VPM_CRN
			&& r.crm == `VPM_CRM && r.op2 == op2;
	endfunction

	always_comb
	begin
		ctx = ctx_in;
		ctx.hyp_control_present = HYP_CONTROL;
		ctx.highest_map_reg_index = HIGHEST_INDEX;
	end

	assign highest_map_reg_index = HIGHEST_INDEX;
	assign hit_six = enc_match(req, `VPM_OP2_SIX);
	assign hit_upper = enc_match(req, `VPM_OP2_UPPER);
	assign hit_any = hit_six || hit_upper;
	assign present_six = HYP_CONTROL && (HIGHEST_INDEX > `VPM_MIN_INDEX_SIX);
	assign present_upper = HYP_CONTROL && (HIGHEST_INDEX == `VPM_FULL_INDEX);

	vpm_access_check u_check
	(
		.present(hit_six ? present_six : present_upper),
		.level(current_privilege_level),
		.ctx(ctx),
		.outcome(outcome)
	);

	// --------------------------------------------
	// Entry writes
	// --------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_entry
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
					entry_r[gi] <= `VPM_ENTRY_RESET;
				else if (req.write && outcome == vpm_pkg::res_direct &&
					((gi < 4 && hit_six) || (gi >= 4 && hit_upper)))
					entry_r[gi] <= req.wdata[(gi % 4) * 16 +: 16];
			end
		end
	endgenerate

	// --------------------------------------------
	// Response
	// --------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			rsp <= '0;
		else
		begin
			rsp.valid <= hit_any;
			rsp.outcome <= hit_any ? outcome : vpm_pkg::res_none;
			// Gated by the hit so an idle cycle never shows a stale page or class
			rsp.page_offset <= (hit_any && outcome == vpm_pkg::res_page) ?
				(hit_six ? `VPM_PAGE_SIX : `VPM_PAGE_UPPER) : 12'h000;
			rsp.trap_class <= (hit_any && (outcome == vpm_pkg::res_trap_hyp ||
				outcome == vpm_pkg::res_trap_mon)) ? `VPM_TRAP_CLASS : 6'h00;
			if (!req.write && outcome == vpm_pkg::res_direct && hit_six)
				rsp.rdata <= {entry_r[3], entry_r[2], entry_r[1], entry_r[0]};
			else if (!req.write && outcome == vpm_pkg::res_direct && hit_upper)
				rsp.rdata <= {entry_r[7], entry_r[6], entry_r[5], entry_r[4]};
			else
				rsp.rdata <= 64'h0000000000000000;
		end
	end

	// --------------------------------------------
	// Translation lookup for IDs 24..31
	// --------------------------------------------
	logic xlat_go;
	logic [2:0] xlat_slot;
	logic slot_present;

	assign xlat_slot = xlat_virtual_id[2:0];
	assign slot_present = xlat_virtual_id[2] ? present_upper : present_six;
	assign xlat_go = xlat_req && ctx_in.hyp_enabled
		&& (xlat_is_kernel ? kernel_map_enable : user_map_enable)
		&& xlat_virtual_id[4:3] == 2'h3 && slot_present
		&& mapping_valid_bits_reg[xlat_virtual_id];

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			xlat_hit <= 1'b0;
			xlat_physical_id <= 16'h0000;
		end
		else
		begin
			xlat_hit <= xlat_go;
			xlat_physical_id <= xlat_go ? entry_r[xlat_slot] : 16'h0000;
		end
	end

	// --------------------------------------------
	// Checks
	// --------------------------------------------
	a_user_undef: assert property (@(posedge clk_sys) disable iff (!rstn)
		(hit_six || hit_upper) && current_privilege_level == vpm_pkg::user_level
		|=> rsp.outcome == vpm_pkg::res_undef)
		else $error("User access not undefined");

	a_page_six: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_six && present_six && current_privilege_level == vpm_pkg::kernel_level
		&& ctx_in.hyp_enabled && ctx_in.nested_virt_bit && ctx_in.nested_virt_mem_bit
		|=> rsp.outcome == vpm_pkg::res_page && rsp.page_offset == 12'h970)
		else $error("Register six not redirected to page");

	a_kernel_trap: assert property (@(posedge clk_sys) disable iff (!rstn)
		(hit_six || hit_upper) && outcome == vpm_pkg::res_trap_hyp
		|-> current_privilege_level == vpm_pkg::kernel_level ##1 rsp.trap_class == 6'h18)
		else $error("Hypervisor trap wrong");

	a_hyp_trap_mon: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_upper && present_upper && current_privilege_level == vpm_pkg::hypervisor_level
		&& ctx_in.monitor_present && ctx_in.trap_lower_levels
		|=> rsp.outcome == vpm_pkg::res_trap_mon)
		else $error("Hypervisor access not trapped to monitor");

	a_monitor_direct: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_six && current_privilege_level == vpm_pkg::monitor_level
		|=> rsp.outcome == vpm_pkg::res_direct)
		else $error("Monitor access not direct");

	a_upper_roundtrip: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_upper && req.write && outcome == vpm_pkg::res_direct
		##1 hit_upper && !req.write && outcome == vpm_pkg::res_direct
		|=> rsp.rdata == $past(req.wdata, 2))
		else $error("Register seven readback mismatch");

	a_rsp_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
		!hit_any |=> !rsp.valid && rsp.outcome == vpm_pkg::res_none
		&& rsp.page_offset == 12'h000 && rsp.trap_class == 6'h00)
		else $error("Response not idle without a hit");

	a_page_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_upper && present_upper && current_privilege_level == vpm_pkg::kernel_level
		&& ctx_in.hyp_enabled && ctx_in.nested_virt_bit && ctx_in.nested_virt_mem_bit
		|=> rsp.outcome == vpm_pkg::res_page && rsp.page_offset == 12'h978)
		else $error("Register seven not redirected to page");

	a_user_no_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		hit_six && req.write && current_privilege_level == vpm_pkg::user_level
		|=> entry_r[0] == $past(entry_r[0]))
		else $error("User write changed register six");

	a_kernel_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
		xlat_req && xlat_is_kernel && !kernel_map_enable |=> !xlat_hit)
		else $error("Kernel translation while disabled");

	a_user_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
		xlat_req && !xlat_is_kernel && !user_map_enable |=> !xlat_hit)
		else $error("User translation while disabled");

	a_entry_low_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
		xlat_go && xlat_virtual_id == 5'h1C |=> xlat_physical_id == $past(entry_r[4]))
		else $error("Virtual 28 not served from register seven low entry");

	a_xlat_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		xlat_req && !ctx_in.hyp_enabled |=> !xlat_hit)
		else $error("Translation while hypervisor off");

	a_valid_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		xlat_req && !mapping_valid_bits_reg[xlat_virtual_id] |=> !xlat_hit)
		else $error("Translation of invalid entry");

endmodule

// ==== design/vpm_access_check.sv ====
// Purpose: Privilege gating for one mapping register access
// Assumes: Context signals are stable in the request cycle
// Notes: Pure combinational decision
`include "vpm_params.svh"

module vpm_access_check
(
	input wire logic present,
	input wire vpm_pkg::level_e level,
	input wire vpm_pkg::access_ctx_s ctx,
	output vpm_pkg::outcome_e outcome
);

	always_comb
	begin
		outcome = vpm_pkg::res_undef;
		if (!present)
			outcome = vpm_pkg::res_undef;
		else
		begin
			case (level)
				vpm_pkg::user_level:
					outcome = vpm_pkg::res_undef;
				vpm_pkg::kernel_level:
				begin
					if (ctx.hyp_enabled && ctx.nested_virt_bit && ctx.nested_virt_mem_bit)
						outcome = vpm_pkg::res_page;
					else if (ctx.hyp_enabled && ctx.nested_virt_bit)
						outcome = (ctx.monitor_present && ctx.trap_lower_levels) ?
							vpm_pkg::res_trap_mon : vpm_pkg::res_trap_hyp;
					else
						outcome = vpm_pkg::res_undef;
				end
				vpm_pkg::hypervisor_level:
					outcome = (ctx.monitor_present && ctx.trap_lower_levels) ?
						vpm_pkg::res_trap_mon : vpm_pkg::res_direct;
				vpm_pkg::monitor_level:
					outcome = vpm_pkg::res_direct;
				default:
					outcome = vpm_pkg::res_undef;
			endcase
		end
	end

endmodule

// ==== design/vpm_params.svh ====
// Purpose: Offsets, encodings, field positions and reset values for the map bank
// Assumes: Included by its bare name from design files
// Notes: Definitions only
`ifndef VPM_PARAMS_SVH
`define VPM_PARAMS_SVH

// --------------------------------------------
// Instruction encodings
// --------------------------------------------
`define VPM_OP0 2'h3
`define VPM_OP1 3'h4
`define VPM_CRN 4'hA
`define VPM_CRM 4'h6
`define VPM_OP2_SIX 3'h6
`define VPM_OP2_UPPER 3'h7

// --------------------------------------------
// Redirect page offsets and trap class
// --------------------------------------------
`define VPM_PAGE_SIX 12'h970
`define VPM_PAGE_UPPER 12'h978
`define VPM_TRAP_CLASS 6'h18

// --------------------------------------------
// Fields and reset values
// --------------------------------------------
`define VPM_ENTRY_W 16
`define VPM_ENTRY_RESET 16'h0000
`define VPM_MIN_INDEX_SIX 3'h5
`define VPM_FULL_INDEX 3'h7
`define VPM_FIRST_SIX 24
`define VPM_FIRST_UPPER 28

`endif

// ==== design/vpm_pkg.sv ====
// Purpose: Types shared by the partition map bank
// Assumes: Nothing beyond the params header
// Notes: Constants live in vpm_params.svh
package vpm_pkg;

	typedef enum logic [1:0] {user_level, kernel_level, hypervisor_level, monitor_level} level_e;

	typedef enum logic [2:0] {res_none, res_direct, res_page, res_trap_hyp, res_trap_mon,
		res_undef} outcome_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] op0;
		logic [2:0] op1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] op2;
		logic [63:0] wdata;
	} sysreg_req_s;

	typedef struct packed {
		logic valid;
		outcome_e outcome;
		logic [11:0] page_offset;
		logic [5:0] trap_class;
		logic [63:0] rdata;
	} sysreg_rsp_s;

	typedef struct packed {
		logic hyp_enabled;
		logic nested_virt_bit;
		logic nested_virt_mem_bit;
		logic monitor_present;
		logic trap_lower_levels;
		logic hyp_control_present;
		logic [2:0] highest_map_reg_index;
	} access_ctx_s;

endpackage

// ==== test/pipe_model.sv ====
// Purpose: Execution pipeline model issuing register move requests
// Assumes: Answer is registered on the taking edge and sampled 1ns after it
// Notes: Released request fields show inverted junk, not the last value
module pipe_model
(
	input wire logic clk_sys,
	input wire vpm_pkg::sysreg_rsp_s rsp,
	output vpm_pkg::sysreg_req_s req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	task automatic issue(input logic wr, input logic [2:0] op2, input logic [63:0] wd,
		output vpm_pkg::sysreg_rsp_s seen);
		vpm_pkg::sysreg_req_s r;
		vpm_pkg::sysreg_req_s idle;
		r = {1'b1, wr, 2'h3, 3'h4, 4'hA, 4'h6, op2, wd};
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge clk_sys);
		req <= r;
		@(posedge clk_sys);
		req <= idle;
		#1;
		seen = rsp;
	endtask

	// Write then read the same register on consecutive edges; seen is the read answer
	task automatic write_read(input logic [2:0] op2, input logic [63:0] wd,
		output vpm_pkg::sysreg_rsp_s seen);
		vpm_pkg::sysreg_req_s r;
		r = {1'b1, 1'b1, 2'h3, 3'h4, 4'hA, 4'h6, op2, wd};
		@(posedge clk_sys);
		req <= r;
		@(posedge clk_sys);
		r.write = 1'b0;
		req <= r;
		@(posedge clk_sys);
		r = ~r;
		r.valid = 1'b0;
		req <= r;
		#1;
		seen = rsp;
	endtask
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the upper partition map bank
// Assumes: Default parameters, all eight map registers present
// Notes: Expectations come from a shadow copy of registers six and seven
`include "vpm_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	vpm_pkg::sysreg_req_s req;
	vpm_pkg::sysreg_rsp_s rsp;
	vpm_pkg::level_e current_privilege_level = vpm_pkg::monitor_level;
	vpm_pkg::access_ctx_s ctx_in = '0;
	logic [31:0] mapping_valid_bits_reg = 32'h0;
	logic kernel_map_enable = 1'b0;
	logic user_map_enable = 1'b0;
	logic xlat_req = 1'b0;
	logic xlat_is_kernel = 1'b0;
	logic [4:0] xlat_virtual_id = 5'h00;
	logic [2:0] highest_map_reg_index;
	logic xlat_hit;
	logic [15:0] xlat_physical_id;
	logic [63:0] shadow [2] = '{64'h0, 64'h0};
	int fails = 0;
	int samples_checked = 0;

	always #10 clk_sys = ~clk_sys;

	virtual_partition_id_map_regs DUT (.clk_sys, .rstn, .req, .current_privilege_level, .ctx_in,
		.mapping_valid_bits_reg, .kernel_map_enable, .user_map_enable, .xlat_req,
		.xlat_is_kernel, .xlat_virtual_id, .rsp, .highest_map_reg_index, .xlat_hit,
		.xlat_physical_id);
	pipe_model pipe (.clk_sys, .rsp, .req);

	// --------------------------------------------
	// Checking helpers
	// --------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] expd);
		samples_checked++;
		if (seen !== expd)
		begin
			fails++;
			$display("MISMATCH at %0t seen %0h expected %0h", $time, seen, expd);
		end
	endtask

	function automatic vpm_pkg::outcome_e exp_out(vpm_pkg::level_e l, vpm_pkg::access_ctx_s c);
		logic tl;
		tl = c.monitor_present & c.trap_lower_levels;
		if (l == vpm_pkg::user_level)
			return vpm_pkg::res_undef;
		if (l == vpm_pkg::kernel_level)
		begin
			if (c.hyp_enabled & c.nested_virt_bit & c.nested_virt_mem_bit)
				return vpm_pkg::res_page;
			if (c.hyp_enabled & c.nested_virt_bit)
				return tl ? vpm_pkg::res_trap_mon : vpm_pkg::res_trap_hyp;
			return vpm_pkg::res_undef;
		end
		if (l == vpm_pkg::hypervisor_level && tl)
			return vpm_pkg::res_trap_mon;
		return vpm_pkg::res_direct;
	endfunction

	// Expectation taken after the answer so level updates have landed
	task automatic access(input logic wr, input logic [2:0] op2, input logic [63:0] wd);
		vpm_pkg::sysreg_rsp_s s;
		vpm_pkg::outcome_e o;
		logic sel;
		logic trap;
		logic [11:0] pg;
		sel = op2[0];
		pipe.issue(wr, op2, wd, s);
		o = exp_out(current_privilege_level, ctx_in);
		trap = (o == vpm_pkg::res_trap_hyp) || (o == vpm_pkg::res_trap_mon);
		pg = (o == vpm_pkg::res_page) ? (sel ? `VPM_PAGE_UPPER : `VPM_PAGE_SIX) : 12'h000;
		check(s.valid, 1'b1);
		check(s.outcome, o);
		check(s.page_offset, pg);
		check(s.trap_class, trap ? `VPM_TRAP_CLASS : 6'h00);
		check(s.rdata, (o == vpm_pkg::res_direct && !wr) ? shadow[sel] : 64'h0);
		if (wr && o == vpm_pkg::res_direct)
			shadow[sel] = wd;
	endtask

	// Back-to-back write and read; needs a level that reaches the register directly
	task automatic roundtrip(input logic [2:0] op2);
		vpm_pkg::sysreg_rsp_s s;
		logic [63:0] wd;
		wd = {$urandom, $urandom};
		pipe.write_read(op2, wd, s);
		check(s.valid, 1'b1);
		check(s.rdata, wd);
		shadow[op2[0]] = wd;
	endtask

	task automatic lookup(input logic kern, input logic [4:0] vid);
		logic hit;
		@(posedge clk_sys);
		xlat_req <= 1'b1;
		xlat_is_kernel <= kern;
		xlat_virtual_id <= vid;
		@(posedge clk_sys);
		xlat_req <= 1'b0;
		#1;
		hit = ctx_in.hyp_enabled & (kern ? kernel_map_enable : user_map_enable)
			& (vid >= 5'h18) & mapping_valid_bits_reg[vid];
		check(xlat_hit, hit);
		check(xlat_physical_id, hit ? shadow[vid[2]][vid[1:0] * 16 +: 16] : 16'h0000);
	endtask

	task automatic conclude();
		$display("samples_checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// --------------------------------------------
	// Main sequence
	// --------------------------------------------
	initial
	begin
		void'($urandom(3374));
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		check(highest_map_reg_index, `VPM_FULL_INDEX);
		access(1'b0, `VPM_OP2_UPPER, 64'h0);
		access(1'b0, `VPM_OP2_SIX, 64'h0);
		// Direct traffic at the two levels that reach the registers
		repeat (40)
		begin
			@(posedge clk_sys);
			current_privilege_level <= $urandom_range(0, 1) ? vpm_pkg::monitor_level
				: vpm_pkg::hypervisor_level;
			access(1'($urandom_range(0, 1)), $urandom_range(0, 1) ? `VPM_OP2_UPPER
				: `VPM_OP2_SIX, {$urandom, $urandom});
		end
		// Every level against every context combination
		for (int i = 0; i < 512; i++)
		begin
			@(posedge clk_sys);
			current_privilege_level <= vpm_pkg::level_e'(i[1:0]);
			ctx_in <= {i[6:2], 4'hF};
			access(i[7], i[8] ? `VPM_OP2_UPPER : `VPM_OP2_SIX, {$urandom, $urandom});
		end
		// Reset in mid-run clears both registers again
		@(posedge clk_sys);
		rstn <= 1'b0;
		current_privilege_level <= vpm_pkg::monitor_level;
		ctx_in <= '0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		shadow = '{64'h0, 64'h0};
		access(1'b0, `VPM_OP2_UPPER, 64'h0);
		access(1'b0, `VPM_OP2_SIX, 64'h0);
		roundtrip(`VPM_OP2_UPPER);
		roundtrip(`VPM_OP2_SIX);
		repeat (200)
		begin
			@(posedge clk_sys);
			ctx_in <= {1'($urandom_range(0, 3) != 0), 8'h0F};
			mapping_valid_bits_reg <= $urandom;
			kernel_map_enable <= 1'($urandom_range(0, 1));
			user_map_enable <= 1'($urandom_range(0, 1));
			lookup(1'($urandom_range(0, 1)), 5'($urandom_range(16, 31)));
		end
		conclude();
	end
endmodule
